// *** logic/rtsr_pkg.sv ***
// rtsr_pkg: offsets, reset values, wake values and field positions of the
// test and status register slice.
// assumes: a 6-bit register address from the serial configuration port.
`default_nettype none

package rtsr_pkg;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [5:0] ADDR_TRIM_A = 6'h29;
    localparam logic [5:0] ADDR_TRIM_B = 6'h2A;
    localparam logic [5:0] ADDR_TRIM_C = 6'h2B;
    localparam logic [5:0] ADDR_TEST_TWO = 6'h2C;
    localparam logic [5:0] ADDR_TEST_ONE = 6'h2D;
    localparam logic [5:0] ADDR_TEST_ZERO = 6'h2E;
    localparam logic [5:0] ADDR_PART_NUM = 6'h30;
    localparam logic [5:0] ADDR_REVISION = 6'h31;
    localparam logic [5:0] ADDR_FREQ_EST = 6'h32;
    localparam logic [5:0] ADDR_CRC_STATUS = 6'h33;
    localparam logic [5:0] ADDR_SIGNAL = 6'h34;

    // ----------------------------------------------------------------
    // reset values and wake-up values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_TRIM_A = 8'h59;
    localparam logic [7:0] RST_TRIM_B = 8'h7F;
    localparam logic [7:0] RST_TRIM_C = 8'h3F;
    localparam logic [7:0] RST_TEST_TWO = 8'h88;
    localparam logic [7:0] RST_TEST_ONE = 8'h31;
    localparam logic [7:0] RST_TEST_ZERO = 8'h0B;
    localparam logic [7:0] RST_STATUS = 8'h00;
    // analog-only values used when the retention option is set
    localparam logic [7:0] WAKE_RET_TEST_TWO = 8'h81;
    localparam logic [7:0] WAKE_RET_TEST_ONE = 8'h35;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int OSC_CAL_EN_BIT = 1;
    localparam int CRC_MATCH_BIT = 7;

    // ----------------------------------------------------------------
    // modulation format codes
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        RTSR_MOD_2FSK = 3'h0,
        RTSR_MOD_GFSK = 3'h1,
        RTSR_MOD_OOK = 3'h3,
        RTSR_MOD_4FSK = 3'h4,
        RTSR_MOD_MSK = 3'h7
    } rtsr_mod_t;

endpackage

`default_nettype wire

// *** logic/rtsr_rw_reg.sv ***
// rtsr_rw_reg: one 8-bit host-writable register that forgets its contents
// in sleep and reloads its reset value on wake-up.
// assumes: write strobe and wake pulse are one-cycle pulses on mclk_i.
`timescale 1ns/1ns
`default_nettype none

module rtsr_rw_reg #(
    parameter logic [7:0] RESET_VALUE = 8'h00
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic wr_en_i,
    input wire logic wake_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] q_o
);

    logic [7:0] val_q;
    logic [7:0] val_d;

    // --------------------------------------------------------------
    // next value: wake reload beats a write, the chip was asleep
    // --------------------------------------------------------------
    always_comb begin
        val_d = val_q;
        if (wake_i) begin
            val_d = RESET_VALUE;
        end else if (wr_en_i) begin
            val_d = wdata_i;
        end
    end

    // storage
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            val_q <= RESET_VALUE;
        end else begin
            val_q <= val_d;
        end
    end

    assign q_o = val_q;

endmodule // rtsr_rw_reg

`default_nettype wire

// *** logic/rtsr_regs.sv ***
// rtsr_regs: analog trim, test-setting and status registers of the receiver.
// assumes: register port strobes, sleep flag, demodulator and packet engine
// inputs all come from logic on mclk_i; no synchronisers are needed.
`timescale 1ns/1ns
`default_nettype none

module rtsr_regs #(
    parameter logic [7:0] PART_CODE = 8'hA5, // arbitrary value
    parameter logic [7:0] REVISION_CODE = 8'h5A // arbitrary value
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [5:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic sleep_i,
    input wire logic analog_retention_option_i,
    input wire logic [2:0] mod_format_i,
    input wire logic [7:0] carrier_offset_value_i,
    input wire logic carrier_offset_valid_i,
    input wire logic crc_check_done_i,
    input wire logic crc_check_match_i,
    input wire logic rx_start_i,
    input wire logic [7:0] signal_strength_value_i,
    output logic [7:0] analog_trim_a_o,
    output logic [7:0] analog_trim_b_o,
    output logic [7:0] analog_trim_c_o,
    output logic [7:0] test_setting_two_analog_o,
    output logic [7:0] test_setting_one_analog_o,
    output logic [7:0] test_setting_zero_o,
    output logic osc_select_cal_enable_o,
    output logic freq_comp_enable_o
);

    // ----------------------------------------------------------------
    // sleep tracking and write decode
    // ----------------------------------------------------------------
    logic sleep_q;
    logic sleep_d;
    logic wake;
    logic wr_ok;
    logic [7:0] test_two_q;
    logic [7:0] test_one_q;

    // wake is the cycle the sleep flag drops
    assign wake = sleep_q & ~sleep_i;
    // a sleeping chip takes no writes
    assign wr_ok = reg_wr_i & ~sleep_i;

    always_comb begin
        sleep_d = sleep_i;
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sleep_q <= 1'b0;
        end else begin
            sleep_q <= sleep_d;
        end
    end

    // ----------------------------------------------------------------
    // volatile host registers
    // ----------------------------------------------------------------
    localparam logic [5:0] VOL_ADDR [6] = '{rtsr_pkg::ADDR_TRIM_A, rtsr_pkg::ADDR_TRIM_B,
        rtsr_pkg::ADDR_TRIM_C, rtsr_pkg::ADDR_TEST_TWO, rtsr_pkg::ADDR_TEST_ONE,
        rtsr_pkg::ADDR_TEST_ZERO};
    localparam logic [7:0] VOL_RST [6] = '{rtsr_pkg::RST_TRIM_A, rtsr_pkg::RST_TRIM_B,
        rtsr_pkg::RST_TRIM_C, rtsr_pkg::RST_TEST_TWO, rtsr_pkg::RST_TEST_ONE,
        rtsr_pkg::RST_TEST_ZERO};
    logic [7:0] vol_q [6];
    // each reloads its reset value on wake, so nothing survives sleep;
    // the host copies of test two and one reload the plain value
    for (genvar g = 0; g < 6; g++) begin : g_vol
        rtsr_rw_reg #(.RESET_VALUE(VOL_RST[g])) u_reg (
            .mclk_i(mclk_i), .rst_i(rst_i), .wake_i(wake),
            .wr_en_i(wr_ok && reg_addr_i == VOL_ADDR[g]),
            .wdata_i(reg_wdata_i), .q_o(vol_q[g]));
    end
    // table order above fixes which byte feeds which view
    assign analog_trim_a_o = vol_q[0];
    assign analog_trim_b_o = vol_q[1];
    assign analog_trim_c_o = vol_q[2];
    assign test_two_q = vol_q[3];
    assign test_one_q = vol_q[4];
    assign test_setting_zero_o = vol_q[5];

    // calibration stage enable is a straight flop bit, resets to one
    assign osc_select_cal_enable_o = test_setting_zero_o[rtsr_pkg::OSC_CAL_EN_BIT];

    // ----------------------------------------------------------------
    // analog-side view of the two test registers
    // ----------------------------------------------------------------
    // bits the retention option flips on the analog side only
    localparam logic [7:0] TWO_FLIP = rtsr_pkg::RST_TEST_TWO ^ rtsr_pkg::WAKE_RET_TEST_TWO;
    localparam logic [7:0] ONE_FLIP = rtsr_pkg::RST_TEST_ONE ^ rtsr_pkg::WAKE_RET_TEST_ONE;
    logic flip_two_q;
    logic flip_two_d;
    logic flip_one_q;
    logic flip_one_d;
    logic [7:0] ana_two_q;
    logic [7:0] ana_two_d;
    logic [7:0] ana_one_q;
    logic [7:0] ana_one_d;

    // flip is latched at wake and dropped once the host rewrites;
    // a host value is taken literally, only the forced value is flipped
    always_comb begin
        flip_two_d = flip_two_q;
        flip_one_d = flip_one_q;
        if (wake) begin
            flip_two_d = analog_retention_option_i;
            flip_one_d = analog_retention_option_i;
        end else begin
            if (wr_ok && reg_addr_i == rtsr_pkg::ADDR_TEST_TWO) begin
                flip_two_d = 1'b0;
            end
            if (wr_ok && reg_addr_i == rtsr_pkg::ADDR_TEST_ONE) begin
                flip_one_d = 1'b0;
            end
        end
        // inversion lands only on the analog lines, never on readback
        ana_two_d = test_two_q ^ (flip_two_q ? TWO_FLIP : 8'h00);
        ana_one_d = test_one_q ^ (flip_one_q ? ONE_FLIP : 8'h00);
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            flip_two_q <= 1'b0;
            flip_one_q <= 1'b0;
            ana_two_q <= rtsr_pkg::RST_TEST_TWO;
            ana_one_q <= rtsr_pkg::RST_TEST_ONE;
        end else begin
            flip_two_q <= flip_two_d;
            flip_one_q <= flip_one_d;
            ana_two_q <= ana_two_d;
            ana_one_q <= ana_one_d;
        end
    end

    assign test_setting_two_analog_o = ana_two_q;
    assign test_setting_one_analog_o = ana_one_q;

    // ----------------------------------------------------------------
    // status capture
    // ----------------------------------------------------------------
    logic is_ook;
    logic comp_q;
    logic comp_d;
    logic [7:0] fe_q;
    logic [7:0] fe_d;
    logic crc_q;
    logic crc_d;
    logic [7:0] signal_strength_q;
    logic [7:0] signal_strength_d;

    assign is_ook = mod_format_i == rtsr_pkg::RTSR_MOD_OOK;

    // status is fed by the radio only; host writes never reach it
    always_comb begin
        comp_d = mod_format_i == rtsr_pkg::RTSR_MOD_2FSK
              || mod_format_i == rtsr_pkg::RTSR_MOD_GFSK
              || mod_format_i == rtsr_pkg::RTSR_MOD_4FSK;
        fe_d = fe_q;
        if (is_ook) begin
            fe_d = 8'h00;
        end else if (carrier_offset_valid_i) begin
            fe_d = carrier_offset_value_i;
        end
        // a comparison in the same cycle as a receive restart wins
        crc_d = crc_q;
        if (crc_check_done_i) begin
            crc_d = crc_check_match_i;
        end else if (rx_start_i) begin
            crc_d = 1'b0;
        end
        signal_strength_d = signal_strength_value_i;
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            comp_q <= 1'b0;
            fe_q <= rtsr_pkg::RST_STATUS;
            crc_q <= 1'b0;
            signal_strength_q <= rtsr_pkg::RST_STATUS;
        end else begin
            comp_q <= comp_d;
            fe_q <= fe_d;
            crc_q <= crc_d;
            signal_strength_q <= signal_strength_d;
        end
    end

    assign freq_comp_enable_o = comp_q;

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    logic [7:0] rd_mux;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    // unmapped offsets read zero; data holds until the next read
    always_comb begin
        rd_mux = 8'h00;
        if (reg_addr_i == rtsr_pkg::ADDR_TRIM_A) begin
            rd_mux = analog_trim_a_o;
        end else if (reg_addr_i == rtsr_pkg::ADDR_TRIM_B) begin
            rd_mux = analog_trim_b_o;
        end else if (reg_addr_i == rtsr_pkg::ADDR_TRIM_C) begin
            rd_mux = analog_trim_c_o;
        end else if (reg_addr_i == rtsr_pkg::ADDR_TEST_TWO) begin
            rd_mux = test_two_q;
        end else if (reg_addr_i == rtsr_pkg::ADDR_TEST_ONE) begin
            rd_mux = test_one_q;
        end else if (reg_addr_i == rtsr_pkg::ADDR_TEST_ZERO) begin
            rd_mux = test_setting_zero_o;
        end else if (reg_addr_i == rtsr_pkg::ADDR_PART_NUM) begin
            rd_mux = PART_CODE;
        end else if (reg_addr_i == rtsr_pkg::ADDR_REVISION) begin
            rd_mux = REVISION_CODE;
        end else if (reg_addr_i == rtsr_pkg::ADDR_FREQ_EST) begin
            rd_mux = is_ook ? 8'h00 : fe_q;
        end else if (reg_addr_i == rtsr_pkg::ADDR_CRC_STATUS) begin
            rd_mux = {crc_q, 7'h00};
        end else if (reg_addr_i == rtsr_pkg::ADDR_SIGNAL) begin
            rd_mux = signal_strength_q;
        end
        rdata_d = reg_rd_i ? rd_mux : rdata_q;
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_o = rdata_q;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    property p_trim_lost;
        wake |=> analog_trim_a_o == rtsr_pkg::RST_TRIM_A
              && analog_trim_c_o == rtsr_pkg::RST_TRIM_C
              && test_setting_zero_o == rtsr_pkg::RST_TEST_ZERO;
    endproperty
    a_trim_lost: assert property (p_trim_lost)
        else $error("volatile register kept its value over sleep");

    property p_wake_two_ret;
        wake && analog_retention_option_i |-> ##2
            test_setting_two_analog_o == rtsr_pkg::WAKE_RET_TEST_TWO;
    endproperty
    a_wake_two_ret: assert property (p_wake_two_ret)
        else $error("test two analog value wrong after retention wake");

    property p_wake_two_read;
        wake ##1 (reg_rd_i && reg_addr_i == rtsr_pkg::ADDR_TEST_TWO)
            |=> reg_rdata_o == rtsr_pkg::RST_TEST_TWO;
    endproperty
    a_wake_two_read: assert property (p_wake_two_read)
        else $error("test two readback not reset value after wake");

    property p_wake_one_ret;
        wake && analog_retention_option_i |-> ##2
            test_setting_one_analog_o == rtsr_pkg::WAKE_RET_TEST_ONE;
    endproperty
    a_wake_one_ret: assert property (p_wake_one_ret)
        else $error("test one analog value wrong after retention wake");

    property p_wake_one_read;
        wake ##1 (reg_rd_i && reg_addr_i == rtsr_pkg::ADDR_TEST_ONE)
            |=> reg_rdata_o == rtsr_pkg::RST_TEST_ONE;
    endproperty
    a_wake_one_read: assert property (p_wake_one_read)
        else $error("test one readback not reset value after wake");

    property p_plain_wake;
        wake && !analog_retention_option_i |-> ##2
            test_setting_two_analog_o == rtsr_pkg::RST_TEST_TWO
            && test_setting_one_analog_o == rtsr_pkg::RST_TEST_ONE;
    endproperty
    a_plain_wake: assert property (p_plain_wake)
        else $error("analog value flipped without retention option");

    property p_osc_cal;
        wr_ok && reg_addr_i == rtsr_pkg::ADDR_TEST_ZERO && !wake
            |=> osc_select_cal_enable_o == $past(reg_wdata_i[1]);
    endproperty
    a_osc_cal: assert property (p_osc_cal)
        else $error("calibration enable does not follow bit 1");

    property p_fe_read;
        reg_rd_i && reg_addr_i == rtsr_pkg::ADDR_FREQ_EST && !is_ook
            |=> reg_rdata_o == $past(fe_q);
    endproperty
    a_fe_read: assert property (p_fe_read)
        else $error("offset estimate readback wrong");

    property p_comp;
        !rst_i |=> freq_comp_enable_o == ($past(mod_format_i) == rtsr_pkg::RTSR_MOD_2FSK
            || $past(mod_format_i) == rtsr_pkg::RTSR_MOD_GFSK
            || $past(mod_format_i) == rtsr_pkg::RTSR_MOD_4FSK);
    endproperty
    a_comp: assert property (p_comp)
        else $error("compensation enable wrong for format");

    property p_ook_zero;
        reg_rd_i && reg_addr_i == rtsr_pkg::ADDR_FREQ_EST && is_ook
            |=> reg_rdata_o == 8'h00;
    endproperty
    a_ook_zero: assert property (p_ook_zero)
        else $error("offset estimate not zero under on-off keying");

    property p_crc_flag;
        (crc_check_done_i && crc_check_match_i |=> crc_q)
        and (rx_start_i && !crc_check_done_i |=> !crc_q);
    endproperty
    a_crc_flag: assert property (p_crc_flag)
        else $error("crc match flag wrong");

    property p_signal_strength_read;
        reg_rd_i && reg_addr_i == rtsr_pkg::ADDR_SIGNAL
            |=> reg_rdata_o == $past(signal_strength_value_i, 2);
    endproperty
    a_signal_strength_read: assert property (p_signal_strength_read)
        else $error("signal strength readback wrong");

    property p_part_read;
        reg_rd_i && reg_addr_i == rtsr_pkg::ADDR_PART_NUM |=> reg_rdata_o == PART_CODE;
    endproperty
    a_part_read: assert property (p_part_read)
        else $error("part code readback wrong");

    property p_ro_write;
        reg_wr_i && reg_addr_i == rtsr_pkg::ADDR_FREQ_EST
            && !carrier_offset_valid_i && !is_ook |=> $stable(fe_q);
    endproperty
    a_ro_write: assert property (p_ro_write)
        else $error("write changed offset estimate");

endmodule // rtsr_regs

`default_nettype wire

// *** testbench/rtsr_host_model.sv ***
// rtsr_host_model: host side of the register port, single-byte accesses.
// assumes: one mclk_i domain; the bench calls wr and rd in turn.
`timescale 1ns/1ns
`default_nettype none

module rtsr_host_model (
    input wire logic mclk_i,
    output logic [5:0] reg_addr_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [7:0] reg_wdata_o,
    input wire logic [7:0] reg_rdata_i
);
    // ----------------------------------------------------------------
    // register port cycles
    // ----------------------------------------------------------------
    // idle lines before the first access
    initial begin
        reg_addr_o = 6'h3F;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_wdata_o = 8'hA5;
    end

    // released lines show inverted values so stale data never looks valid
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        reg_addr_o <= a;
        reg_wdata_o <= d;
        reg_wr_o <= 1'b1;
        @(posedge mclk_i);
        reg_wr_o <= 1'b0;
        reg_addr_o <= ~a;
        reg_wdata_o <= ~d;
    endtask

    // data is taken one edge after the strobe edge, while it stands
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge mclk_i);
        reg_addr_o <= a;
        reg_rd_o <= 1'b1;
        @(posedge mclk_i);
        reg_rd_o <= 1'b0;
        reg_addr_o <= ~a;
        @(posedge mclk_i);
        d = reg_rdata_i;
    endtask
endmodule // rtsr_host_model

`default_nettype wire

// *** testbench/test_radio_test_and_status_regs.sv ***
// test_radio_test_and_status_regs: random and corner tests of rtsr_regs.
// assumes: rtsr_pkg and rtsr_host_model are compiled first.
`timescale 1ns/1ns
`default_nettype none

module test_radio_test_and_status_regs;
    localparam logic [7:0] PART = 8'hC3; // arbitrary value
    localparam logic [7:0] REV = 8'h3C; // arbitrary value
    localparam logic [5:0] RW_A [6] = '{6'h29, 6'h2A, 6'h2B, 6'h2C, 6'h2D, 6'h2E};
    localparam logic [7:0] RW_R [6] = '{8'h59, 8'h7F, 8'h3F, 8'h88, 8'h31, 8'h0B};
    localparam logic [2:0] MODS [5] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h7};
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic sleep = 1'b0;
    logic ret = 1'b0;
    logic [2:0] mod = 3'h0;
    logic [7:0] off_v = 8'h00;
    logic off_vld = 1'b0;
    logic crc_done = 1'b0;
    logic crc_match = 1'b0;
    logic rx_start = 1'b0;
    logic [7:0] signal_strength = 8'h00;
    logic [5:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] tr_a;
    logic [7:0] tr_b;
    logic [7:0] tr_c;
    logic [7:0] an_two;
    logic [7:0] an_one;
    logic [7:0] t_zero;
    logic osc_en;
    logic comp_en;
    int n_fail = 0;
    int samples_checked = 0;
    logic [31:0] seed = 32'h06D5E732;
    logic [7:0] got;
    logic [7:0] wv [6];

    // ----------------------------------------------------------------
    // clock, design and host
    // ----------------------------------------------------------------
    initial begin
        forever #20 mclk_i = ~mclk_i;
    end

    rtsr_regs #(.PART_CODE(PART), .REVISION_CODE(REV)) dut (
        .mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .sleep_i(sleep),
        .analog_retention_option_i(ret), .mod_format_i(mod),
        .carrier_offset_value_i(off_v), .carrier_offset_valid_i(off_vld),
        .crc_check_done_i(crc_done), .crc_check_match_i(crc_match),
        .rx_start_i(rx_start), .signal_strength_value_i(signal_strength), .analog_trim_a_o(tr_a),
        .analog_trim_b_o(tr_b), .analog_trim_c_o(tr_c),
        .test_setting_two_analog_o(an_two), .test_setting_one_analog_o(an_one),
        .test_setting_zero_o(t_zero), .osc_select_cal_enable_o(osc_en),
        .freq_comp_enable_o(comp_en));

    rtsr_host_model host (.mclk_i(mclk_i), .reg_addr_o(addr), .reg_wr_o(wr),
        .reg_rd_o(rd), .reg_wdata_o(wdata), .reg_rdata_i(rdata));

    // ----------------------------------------------------------------
    // expectations and checks
    // ----------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // on-off keying hides the estimate, only the FSK family compensates
    function automatic logic [7:0] exp_est(input logic [2:0] m, input logic [7:0] v);
        return (m == 3'h3) ? 8'h00 : v;
    endfunction

    function automatic logic [7:0] exp_comp(input logic [2:0] m);
        return {7'h00, (m == 3'h0) || (m == 3'h1) || (m == 3'h4)};
    endfunction

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic crc_ev(input logic d, input logic m, input logic s, input logic [7:0] e);
        @(posedge mclk_i);
        crc_done <= d;
        crc_match <= m;
        rx_start <= s;
        @(posedge mclk_i);
        crc_done <= 1'b0;
        rx_start <= 1'b0;
        host.rd(6'h33, got);
        chk(got, e);
    endtask

    task automatic tally_and_finish;
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // watchdog: the tests need well under a thousand cycles
    initial begin
        #200000;
        n_fail++;
        tally_and_finish();
    end

    // ----------------------------------------------------------------
    // test sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            host.rd(RW_A[i], got);
            chk(got, RW_R[i]);
        end
        chk({7'h00, osc_en}, 8'h01);
        $display("test reset done");
        for (int r = 0; r < 2; r++) begin
            for (int i = 0; i < 6; i++) begin
                seed = lfsr(seed);
                wv[i] = seed[7:0];
                host.wr(RW_A[i], wv[i]);
            end
            // let the last write land before looking at the outputs
            @(posedge mclk_i);
            chk(an_two, wv[3]);
            chk(an_one, wv[4]);
            chk(t_zero, wv[5]);
            chk({7'h00, osc_en}, {7'h00, wv[5][1]});
            // a write while asleep must be dropped
            @(posedge mclk_i);
            sleep <= 1'b1;
            ret <= r[0];
            host.wr(6'h29, ~wv[0]);
            @(posedge mclk_i);
            chk(tr_a, wv[0]);
            sleep <= 1'b0;
            // first read lands one cycle after wake: test two on the first pass, test one on the second
            for (int i = 0; i < 6; i++) begin
                host.rd(RW_A[(i + 3 + r) % 6], got);
                chk(got, RW_R[(i + 3 + r) % 6]);
            end
            chk(an_two, r ? 8'h81 : 8'h88);
            chk(an_one, r ? 8'h35 : 8'h31);
            chk(tr_a, 8'h59);
            chk(tr_b, 8'h7F);
            chk(tr_c, 8'h3F);
            chk(t_zero, 8'h0B);
        end
        $display("test sleep done");
        signal_strength <= 8'h6E;
        for (int i = 0; i < 5; i++) begin
            host.wr(6'h30 + 6'(i), 8'hFF);
        end
        host.wr(6'h2F, 8'hFF);
        host.rd(6'h30, got);
        chk(got, PART);
        host.rd(6'h31, got);
        chk(got, REV);
        host.rd(6'h33, got);
        chk(got, 8'h00);
        host.rd(6'h2F, got);
        chk(got, 8'h00);
        host.rd(6'h32, got);
        chk(got, 8'h00);
        host.rd(6'h34, got);
        chk(got, 8'h6E);
        $display("test status write done");
        for (int i = 0; i < 5; i++) begin
            seed = lfsr(seed);
            @(posedge mclk_i);
            mod <= MODS[i];
            off_v <= (i == 0) ? 8'h80 : seed[7:0];
            off_vld <= 1'b1;
            signal_strength <= seed[15:8];
            @(posedge mclk_i);
            off_vld <= 1'b0;
            host.rd(6'h32, got);
            chk(got, exp_est(MODS[i], (i == 0) ? 8'h80 : seed[7:0]));
            chk({7'h00, comp_en}, exp_comp(MODS[i]));
            host.rd(6'h34, got);
            chk(got, seed[15:8]);
        end
        $display("test estimate done");
        crc_ev(1'b1, 1'b1, 1'b0, 8'h80);
        crc_ev(1'b0, 1'b0, 1'b1, 8'h00);
        crc_ev(1'b1, 1'b0, 1'b0, 8'h00);
        crc_ev(1'b1, 1'b1, 1'b0, 8'h80);
        crc_ev(1'b1, 1'b1, 1'b1, 8'h80);
        crc_ev(1'b1, 1'b0, 1'b0, 8'h00);
        $display("test crc done");
        tally_and_finish();
    end
endmodule // test_radio_test_and_status_regs

`default_nettype wire
